// *** rtl/dual_rd_pkg.sv ***
// =====================================================================
// shared constants of the dual result reader
package dual_rd_pkg;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          SCLK_PERIOD_NS = 160;
    // half period of the serial clock in system clock cycles
    localparam int          SCLK_HALF_CYC  =
        SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [5:0]  WORD_BITS_LONG  = 6'h10;
    localparam logic [5:0]  WORD_BITS_SHORT = 6'h0e;
    localparam logic [5:0]  TAIL_BITS       = 6'h0e;
    localparam logic [3:0]  GAP_CYC         = 4'h4;
    localparam logic [15:0] DUMMY_WORD      = 16'h0000;
    localparam logic [31:0] SHIFT_RESET     = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_FRAME,
        ST_END,
        ST_GAP
    } rd_state_e;
endpackage

// *** rtl/sclk_divider.sv ***
`timescale 1ns/1ns
// =====================================================================
// serial clock divider: idles high, toggles every half period while run
module sclk_divider
    import dual_rd_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      sclk_r,
    output logic      fall_tick_r,
    output logic      rise_tick_r
);
    logic [4:0] cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r       <= 5'h00;
            sclk_r      <= 1'b1;
            fall_tick_r <= 1'b0;
            rise_tick_r <= 1'b0;
        end else if (!run) begin
            cnt_r       <= 5'h00;
            sclk_r      <= 1'b1;
            fall_tick_r <= 1'b0;
            rise_tick_r <= 1'b0;
        end else if (cnt_r == 5'(SCLK_HALF_CYC - 1)) begin
            cnt_r       <= 5'h00;
            sclk_r      <= ~sclk_r;
            fall_tick_r <= sclk_r;
            rise_tick_r <= ~sclk_r;
        end else begin
            cnt_r       <= cnt_r + 5'h01;
            fall_tick_r <= 1'b0;
            rise_tick_r <= 1'b0;
        end
    end
endmodule

// *** rtl/dual_rd_host.sv ***
`timescale 1ns/1ns
// How it works
// RULE1: conversion-done falling edge starts a result read
// RULE2: transmit frame drives converter chip select
// RULE3: frame low per word, high between words
// RULE4: word is 16 or 14 bits
// RULE5: sample result bits on serial clock falling edge
// RULE6: both result lines captured together when enabled
// RULE7: second line uses the first port's clock
// RULE8: transmit frame also acts as receive frames
// RULE9: dummy control word sent, its frame starts read
// RULE10: continuous clock mode keeps clock and frame internal
// RULE11: converter drives MSB on chip select fall
// RULE12: held frame gives other result after 14 clocks
// RULE13: frame released after each word completes
module dual_rd_host
    import dual_rd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        read_enable,
    input  wire logic        word_length_field,
    input  wire logic        secondary_receive_enable,
    input  wire logic        continuous_clock,
    input  wire logic        conv_busy,
    input  wire logic        result_out_first,
    input  wire logic        result_out_second,
    output logic             port0_transmit_clock,
    output logic             transmit_frame_sync,
    output logic             transmit_data,
    output logic             read_active,
    output logic             result_valid,
    output logic [15:0]      result_first,
    output logic [15:0]      result_second
);
    localparam int LEAD_MAX = 20;
    localparam int HALF_MAX = 9;

    // =================================================================
    // pin synchronisers
    logic busy_s1_r, busy_s2_r, busy_s3_r;
    logic da_s1_r, da_s2_r, db_s1_r, db_s2_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_s1_r <= 1'b0;
            busy_s2_r <= 1'b0;
            busy_s3_r <= 1'b0;
            da_s1_r   <= 1'b0;
            da_s2_r   <= 1'b0;
            db_s1_r   <= 1'b0;
            db_s2_r   <= 1'b0;
        end else begin
            busy_s1_r <= conv_busy;
            busy_s2_r <= busy_s1_r;
            busy_s3_r <= busy_s2_r;
            da_s1_r   <= result_out_first;
            da_s2_r   <= da_s1_r;
            db_s1_r   <= result_out_second;
            db_s2_r   <= db_s1_r;
        end
    end

    logic busy_fall;
    assign busy_fall = busy_s3_r & ~busy_s2_r;

    // =================================================================
    // serial clock
    rd_state_e state_r;
    logic      run_r;
    logic      fall_tick, rise_tick;

    sclk_divider u_div (
        .clk         (clk),
        .rstn        (rstn),
        .run         (run_r),
        .sclk_r      (port0_transmit_clock),
        .fall_tick_r (fall_tick),
        .rise_tick_r (rise_tick)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 1'b0;
        end else begin
            run_r <= continuous_clock || state_r == ST_ARM
                     || state_r == ST_FRAME || state_r == ST_END; // see RULE10
        end
    end

    // =================================================================
    // frame sequencing
    logic [5:0] bit_cnt_r;
    logic [5:0] word_bits_r;
    logic [5:0] total_bits_r;
    logic       dual_r;
    logic [3:0] gap_cnt_r;
    logic       frame_cmd;

    // in continuous clock mode arm on a rising edge so chip select never falls with the clock
    assign frame_cmd = !continuous_clock || rise_tick;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r      <= ST_IDLE;
            bit_cnt_r    <= 6'h00;
            word_bits_r  <= WORD_BITS_LONG;
            total_bits_r <= WORD_BITS_LONG;
            dual_r       <= 1'b1;
            gap_cnt_r    <= 4'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (read_enable && busy_fall) begin // see RULE1
                        state_r     <= ST_ARM;
                        dual_r      <= secondary_receive_enable;
                        word_bits_r <= word_length_field ? WORD_BITS_LONG
                                                         : WORD_BITS_SHORT;
                        total_bits_r <= (word_length_field ? WORD_BITS_LONG
                                                           : WORD_BITS_SHORT)
                                        + (secondary_receive_enable
                                           ? 6'h00 : TAIL_BITS);
                    end
                end
                ST_ARM: begin
                    bit_cnt_r <= 6'h00;
                    if (frame_cmd) begin
                        state_r <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (fall_tick) begin
                        bit_cnt_r <= bit_cnt_r + 6'h01;
                        if (bit_cnt_r == total_bits_r - 6'h01) begin
                            state_r <= ST_END; // see RULE4
                        end
                    end
                end
                ST_END: begin
                    if (rise_tick) begin // see RULE13
                        state_r   <= ST_GAP;
                        gap_cnt_r <= GAP_CYC;
                    end
                end
                ST_GAP: begin
                    gap_cnt_r <= gap_cnt_r - 4'h1;
                    if (gap_cnt_r == 4'h1) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // transmit frame is chip select and the internal receive frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            transmit_frame_sync <= 1'b1;
        end else if (state_r == ST_ARM && frame_cmd) begin
            transmit_frame_sync <= 1'b0; // see RULE2 see RULE3 see RULE8
        end else if (state_r == ST_END && rise_tick) begin
            transmit_frame_sync <= 1'b1; // see RULE3 see RULE13
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            read_active <= 1'b0;
        end else begin
            read_active <= state_r != ST_IDLE;
        end
    end

    // =================================================================
    // dummy control word, shifted out msb first on rising edges
    logic [15:0] tx_sh_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh_r       <= DUMMY_WORD;
            transmit_data <= 1'b0;
        end else if (state_r == ST_ARM && frame_cmd) begin
            tx_sh_r       <= {DUMMY_WORD[14:0], 1'b0}; // see RULE9
            transmit_data <= DUMMY_WORD[15];
        end else if (state_r == ST_FRAME && rise_tick) begin
            tx_sh_r       <= {tx_sh_r[14:0], 1'b0};
            transmit_data <= tx_sh_r[15];
        end
    end

    // =================================================================
    // receive shifters, both on the same falling edge tick
    logic [31:0] sh_a_r;
    logic [15:0] sh_b_r;
    logic        sample;

    assign sample = state_r == ST_FRAME && fall_tick;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_a_r <= SHIFT_RESET;
        end else if (state_r == ST_ARM) begin
            sh_a_r <= SHIFT_RESET;
        end else if (sample) begin
            sh_a_r <= {sh_a_r[30:0], da_s2_r}; // see RULE5 see RULE11
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_b_r <= 16'h0000;
        end else if (state_r == ST_ARM) begin
            sh_b_r <= 16'h0000;
        end else if (sample && dual_r) begin
            sh_b_r <= {sh_b_r[14:0], db_s2_r}; // see RULE6 see RULE7
        end
    end

    // =================================================================
    // result hand-off
    logic [15:0] single_first;

    // single-line read: the first word sits above the 14-bit tail
    assign single_first = 16'(sh_a_r >> TAIL_BITS) & ((16'h0001 << word_bits_r) - 16'h0001);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_first  <= 16'h0000;
            result_second <= 16'h0000;
            result_valid  <= 1'b0;
        end else if (state_r == ST_END && rise_tick) begin
            result_valid <= 1'b1;
            if (dual_r) begin
                result_first  <= sh_a_r[15:0];
                result_second <= sh_b_r;
            end else begin
                result_first  <= single_first;
                result_second <= {2'b00, sh_a_r[13:0]}; // see RULE12
            end
        end else begin
            result_valid <= 1'b0;
        end
    end

    // =================================================================
    // checks
    logic [5:0] fall_cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fall_cnt_r <= 6'h00;
        end else if (transmit_frame_sync) begin
            fall_cnt_r <= 6'h00;
        end else if (fall_tick) begin
            fall_cnt_r <= fall_cnt_r + 6'h01;
        end
    end

    sequence seq_frame_close;
        $rose(transmit_frame_sync);
    endsequence

    sequence seq_frame_quiet;
        transmit_frame_sync [*4];
    endsequence

    AST_START_ON_DONE: assert property (@(posedge clk) disable iff (!rstn) // see RULE1
        state_r == ST_IDLE && read_enable && busy_fall
        |-> ##[1:LEAD_MAX] !transmit_frame_sync)
        else $error("read did not start after conversion done");
    AST_IDLE_FRAME_HIGH: assert property (@(posedge clk) disable iff (!rstn) // see RULE3
        state_r == ST_IDLE |-> transmit_frame_sync)
        else $error("frame low while idle");
    AST_CS_NOT_WITH_FALL: assert property (@(posedge clk) disable iff (!rstn) // see RULE2
        $fell(transmit_frame_sync) |-> port0_transmit_clock && !fall_tick)
        else $error("chip select fell with the serial clock");
    AST_WORD_LENGTH: assert property (@(posedge clk) disable iff (!rstn) // see RULE4
        seq_frame_close |-> fall_cnt_r == total_bits_r)
        else $error("wrong number of clocks in frame");
    AST_SAMPLE_FALL_ONLY: assert property (@(posedge clk) disable iff (!rstn) // see RULE5
        state_r == ST_FRAME && !fall_tick |=> $stable(sh_a_r))
        else $error("result sampled off a falling edge");
    AST_SECOND_LINE: assert property (@(posedge clk) disable iff (!rstn) // see RULE6
        sample && dual_r |=> sh_b_r[0] == $past(db_s2_r))
        else $error("second line not captured with first");
    AST_CONT_CLOCK: assert property (@(posedge clk) disable iff (!rstn) // see RULE10
        continuous_clock && $past(continuous_clock) && $rose(port0_transmit_clock)
        |-> ##[1:HALF_MAX] !port0_transmit_clock)
        else $error("continuous clock stopped");
    AST_RELEASE_AND_GAP: assert property (@(posedge clk) disable iff (!rstn) // see RULE13
        seq_frame_close |-> result_valid ##0 seq_frame_quiet)
        else $error("frame not released or result not delivered");
    AST_DUMMY_WORD: assert property (@(posedge clk) disable iff (!rstn) // see RULE9
        $fell(transmit_frame_sync) |-> transmit_data == DUMMY_WORD[15])
        else $error("dummy word not sent with frame");
endmodule

// *** sim/conv_model.sv ***
`timescale 1ns/1ns
// =====================================================================
// converter model: two result lines, busy output, chip select read
module conv_model #(
    parameter int CONV_NS = 600
) (
    input  wire logic        conv_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic [13:0] val_a,
    input  wire logic [13:0] val_b,
    output logic             busy,
    output logic             dout_a,
    output logic             dout_b
);
    logic [13:0] res_a;
    logic [13:0] res_b;
    logic [31:0] sh_a;
    logic [31:0] sh_b;
    logic        hold_a;
    logic        hold_b;

    initial begin
        busy = 1'b0;
        res_a = 14'h0000;
        res_b = 14'h0000;
        sh_a = 32'h0000_0000;
        sh_b = 32'h0000_0000;
        hold_a = 1'b0;
        hold_b = 1'b0;
    end

    // busy falls once results are ready and acts as the interrupt
    always @(negedge conv_n) begin
        busy = 1'b1;
        #CONV_NS;
        res_a = val_a;
        res_b = val_b;
        busy = 1'b0;
    end

    // select fall shows the msb; the other result follows after 14 bits
    always @(negedge cs_n) begin
        sh_a <= {res_a, res_b, 4'h0};
        sh_b <= {res_b, res_a, 4'h0};
    end

    always @(negedge sclk) begin
        if (!cs_n) begin
            sh_a <= #3 sh_a << 1;
            sh_b <= #3 sh_b << 1;
        end
    end

    // released lines show the inverse of the last bit
    always @(posedge cs_n) begin
        hold_a <= ~sh_a[31];
        hold_b <= ~sh_b[31];
    end

    assign dout_a = cs_n ? hold_a : sh_a[31];
    assign dout_b = cs_n ? hold_b : sh_b[31];
endmodule

// *** sim/test_dual_rd_host.sv ***
`timescale 1ns/1ns
// =====================================================================
// bench of the dual result reader
module test_dual_rd_host;
    import dual_rd_pkg::*;
    logic        clk, rstn, read_enable, word_length_field;
    logic        secondary_receive_enable, continuous_clock, conv_n;
    logic        conv_busy, result_out_first, result_out_second;
    logic        port0_transmit_clock, transmit_frame_sync;
    logic        transmit_data, read_active, result_valid;
    logic [15:0] result_first, result_second;
    logic [13:0] val_a, val_b;
    int          err_total, compares, cycles, falls, frames, valids, dbad;

    dual_rd_host dut_u (
        .clk(clk), .rstn(rstn), .read_enable(read_enable),
        .word_length_field(word_length_field),
        .secondary_receive_enable(secondary_receive_enable),
        .continuous_clock(continuous_clock), .conv_busy(conv_busy),
        .result_out_first(result_out_first),
        .result_out_second(result_out_second),
        .port0_transmit_clock(port0_transmit_clock),
        .transmit_frame_sync(transmit_frame_sync),
        .transmit_data(transmit_data), .read_active(read_active),
        .result_valid(result_valid), .result_first(result_first),
        .result_second(result_second)
    );

    conv_model conv_u (
        .conv_n(conv_n), .cs_n(transmit_frame_sync),
        .sclk(port0_transmit_clock), .val_a(val_a), .val_b(val_b),
        .busy(conv_busy), .dout_a(result_out_first),
        .dout_b(result_out_second)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // =================================================================
    // monitors and timeout
    always @(negedge port0_transmit_clock) if (!transmit_frame_sync) falls++;
    always @(negedge transmit_frame_sync) begin
        frames++;
        falls = 0;
    end
    always @(posedge clk) begin
        if (result_valid === 1'b1) valids++;
        if (rstn && transmit_data !== 1'b0) dbad++;
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            $display("wrong value at %0t: timeout", $time);
            results();
        end
    end

    // =================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic convert(input logic [13:0] a, input logic [13:0] b);
        @(posedge clk);
        #1 val_a = a;
        val_b = b;
        conv_n = 1'b0;
        @(posedge clk);
        #1 conv_n = 1'b1;
    endtask

    task automatic do_read(input logic wl, input logic sec, input logic cont,
                           input logic [13:0] a, input logic [13:0] b);
        logic [31:0] sa, sb;
        int          n, tot, k;
        sa = {a, b, 4'h0};
        sb = {b, a, 4'h0};
        n = wl ? 16 : 14;
        tot = sec ? n : n + 14;
        @(posedge clk);
        #1 word_length_field = wl;
        secondary_receive_enable = sec;
        continuous_clock = cont;
        read_enable = 1'b1;
        convert(a, b);
        k = 0;
        while (result_valid !== 1'b1 && k < 2000) begin
            @(posedge clk);
            #1 k++;
        end
        check(k < 2000, 1, "no result");
        check(result_first, 16'(sa >> (32 - n)),
              "first");
        if (sec) check(result_second, 16'(sb >> (32 - n)),
                       "second");
        else check(result_second,
                   16'((sa >> (18 - n)) & 32'h3fff), "tail");
        check(falls, tot, "clock falls in frame");
        check(transmit_frame_sync, 1'b1, "frame not released");
        check(dbad, 0, "control word");
        if (!cont) check(port0_transmit_clock, 1'b1,
                         "clock idle");
        repeat (10) @(posedge clk);
        #1 check(read_active, 1'b0, "still active");
    endtask

    // =================================================================
    // scenarios
    task automatic test_reads;
        do_read(1'b1, 1'b1, 1'b0, 14'h2a5c, 14'h1337);
        do_read(1'b0, 1'b1, 1'b0, 14'h3fff, 14'h0001);
        do_read(1'b1, 1'b0, 1'b0, 14'h1234, 14'h2bcd);
        do_read(1'b0, 1'b0, 1'b0, 14'h0f0f, 14'h30c3);
        $display("test reads done");
    endtask

    task automatic test_continuous;
        logic v;
        @(posedge clk);
        #1 continuous_clock = 1'b1;
        repeat (40) @(posedge clk);
        #1 v = port0_transmit_clock;
        repeat (SCLK_HALF_CYC) @(posedge clk);
        #1 check(port0_transmit_clock, !v, "clock not running");
        do_read(1'b1, 1'b1, 1'b1, 14'h0a55, 14'h35aa);
        do_read(1'b0, 1'b0, 1'b1, 14'h2001, 14'h1ffe);
        $display("test continuous done");
    endtask

    task automatic test_disabled;
        int f, v;
        // drop the free clock in its low phase so no high phase is cut
        @(negedge port0_transmit_clock);
        @(posedge clk);
        #1 read_enable = 1'b0;
        continuous_clock = 1'b0;
        f = frames;
        v = valids;
        convert(14'h1111, 14'h2222);
        repeat (200) @(posedge clk);
        #1 check(frames, f, "frame while disabled");
        check(valids, v, "valid while disabled");
        $display("test disabled done");
    endtask

    initial begin
        rstn = 1'b0;
        read_enable = 1'b0;
        word_length_field = 1'b1;
        secondary_receive_enable = 1'b1;
        continuous_clock = 1'b0;
        conv_n = 1'b1;
        val_a = 14'h0000;
        val_b = 14'h0000;
        repeat (20) @(posedge clk);
        #1 check(transmit_frame_sync, 1'b1, "reset frame");
        rstn = 1'b1;
        test_reads();
        test_continuous();
        test_disabled();
        results();
    end
endmodule
